//--- include/pkl_pkg.sv
/*
  Shared constants and carrier types for the two-wire host link controller.
  Assumes a 20 MHz system clock and a peripheral that makes the link clock.
*/
package pkl_pkg;

  // System clock rate in kHz.
  localparam int unsigned CLK_KHZ       = 20000;
  // Least inhibit time before a host transfer, in microseconds.
  localparam int unsigned INHIBIT_US    = 60;
  localparam int unsigned INHIBIT_CYC   = (INHIBIT_US * CLK_KHZ + 999) / 1000;
  // Default watchdog limit between link clock falling edges, in microseconds.
  localparam int unsigned WATCHDOG_US   = 2000;
  localparam int unsigned WATCHDOG_CYC  = (WATCHDOG_US * CLK_KHZ) / 1000;
  // Frame layout: start, eight data bits, parity, stop.
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [3:0]  BIT_PARITY    = 4'h8;
  localparam logic [3:0]  BIT_STOP      = 4'h9;
  localparam logic [3:0]  BIT_ACK       = 4'ha;
  localparam logic [3:0]  BIT_LAST_DATA = 4'h7;
  // Operating modes of the keyboard channel.
  localparam logic [1:0]  MODE_ONE      = 2'h1;
  localparam logic [1:0]  MODE_TWO      = 2'h2;
  localparam logic [1:0]  MODE_THREE    = 2'h3;
  // Reply codes from the peripheral.
  localparam logic [7:0]  CODE_ACK      = 8'hfa;
  localparam logic [7:0]  CODE_RESEND   = 8'hfe;
  // Translation marker for a key release in the second code set.
  localparam logic [7:0]  CODE_BREAK    = 8'hf0;
  localparam logic [7:0]  BREAK_BIT     = 8'h80;

  // Channel state, Gray coded in the order listed.
  typedef enum logic [3:0] {
    PKL_IDLE    = 4'b0000,
    PKL_RX      = 4'b0001,
    PKL_INHIBIT = 4'b0011,
    PKL_REQ     = 4'b0010,
    PKL_TX      = 4'b0110,
    PKL_HOLD    = 4'b0111
  } pkl_state_t;

  // Pin group of one link: inputs seen and open-drain drive.
  typedef struct packed {
    logic clk_in;
    logic dat_in;
  } pkl_pin_in_t;

  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic dat_out;
    logic dat_oe;
  } pkl_pin_out_t;

  // Received byte with its status.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_err;
  } pkl_rx_t;

  // Odd parity bit for a data byte.
  function automatic logic pkl_odd_parity(input logic [7:0] d);
    pkl_odd_parity = ~(^d);
  endfunction

endpackage

//--- verification/pkl_host_props.sv
/* Port checker for the two-channel host link controller.
   Assumes it is bound to pkl_host and sees the package constants. */
`timescale 1ns/1ps
module pkl_host_props import pkl_pkg::*; (
  input wire logic         clk,
  input wire logic         rst_b,
  input wire pkl_pin_out_t kbd_out,
  input wire logic         kbd_tx_valid,
  input wire logic         kbd_tx_ready,
  input wire logic         kbd_tx_done,
  input wire logic         kbd_tx_nack,
  input wire pkl_rx_t      kbd_rx,
  input wire pkl_rx_t      aux_rx,
  input wire logic [1:0]   mode,
  input wire logic         irq1,
  input wire logic         irq12
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int inh_cnt;

  // Counts cycles of clock inhibit while data is released.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inh_cnt <= 0;
    end else begin
      inh_cnt <= (kbd_out.clk_oe && !kbd_out.dat_oe) ? inh_cnt + 1 : 0;
    end
  end

  chk_inhibit_len: assert property ($rose(kbd_out.dat_oe) && $past(kbd_out.clk_oe)
    |-> inh_cnt >= INHIBIT_CYC) else $error("clock inhibit too short");
  chk_request_form: assert property ($rose(kbd_out.dat_oe) && $past(kbd_out.clk_oe)
    |-> !kbd_out.clk_oe) else $error("request kept the clock low");
  chk_tx_take: assert property (kbd_tx_valid && kbd_tx_ready |=> kbd_out.clk_oe)
    else $error("taken command did not inhibit");
  chk_open_drain: assert property (!kbd_out.clk_out && !kbd_out.dat_out)
    else $error("line driven high");
  chk_ready_idle: assert property (kbd_tx_ready |-> !kbd_out.clk_oe && !kbd_out.dat_oe)
    else $error("ready while lines held");
  chk_mode_one: assert property (mode == MODE_ONE |-> !kbd_tx_ready)
    else $error("ready in inbound-only mode");
  chk_nack_done: assert property (kbd_tx_nack |-> kbd_tx_done)
    else $error("nack without done");
  chk_hold_after: assert property (kbd_tx_done |-> ##[0:2] kbd_out.clk_oe)
    else $error("no inhibit after frame");
  chk_kbd_irq: assert property (irq1 == kbd_rx.valid && (!irq1 || kbd_out.clk_oe))
    else $error("irq1 differs from receive");
  chk_aux_irq: assert property (irq12 == aux_rx.valid)
    else $error("irq12 differs from receive");
  chk_boot_mode: assert property ($rose(rst_b) |-> mode == MODE_TWO)
    else $error("wrong mode after reset");

  cover property (kbd_tx_done);
  cover property (kbd_tx_nack);
  cover property (aux_rx.valid);
endmodule // pkl_host_props

bind pkl_host pkl_host_props u_props (.clk(clk), .rst_b(rst_b), .kbd_out(kbd_out),
  .kbd_tx_valid(kbd_tx_valid), .kbd_tx_ready(kbd_tx_ready), .kbd_tx_done(kbd_tx_done),
  .kbd_tx_nack(kbd_tx_nack), .kbd_rx(kbd_rx), .aux_rx(aux_rx), .mode(mode),
  .irq1(irq1), .irq12(irq12));

//--- verification/pkl_periph.sv
/* Behavioural peripheral on one two-wire link; it makes every clock pulse.
   Assumes pulled-up lines resolved outside from both parties' enables. */
`timescale 1ns/1ps
module pkl_periph (
  input  wire logic clk_line,
  input  wire logic dat_line,
  output logic      clk_oe,
  output logic      dat_oe
);
  logic       busy = 1'b0;
  logic       ack_bad = 1'b0;
  logic       mute = 1'b0;
  logic [9:0] got = '0;
  int         n_clash = 0;
  initial clk_oe = 1'b0;
  initial dat_oe = 1'b0;

  // One 400 ns clock pulse, low for the first half.
  task automatic pulse();
    clk_oe = 1'b1;
    #200;
    clk_oe = 1'b0;
    #200;
  endtask

  // Sends one frame once the host frees the clock; bp flips the parity.
  task automatic send(input logic [7:0] b, input logic bp);
    logic [10:0] f;
    wait (clk_line === 1'b1 && !busy);
    busy = 1'b1;
    f = {1'b1, ~(^b) ^ bp, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      dat_oe = ~f[i];
      #100;
      pulse();
      if (i < 10 && clk_line !== 1'b1) n_clash++;
    end
    dat_oe = 1'b0;
    busy = 1'b0;
  endtask

  // Clocks in a host command, acknowledges it, then answers with a code.
  always begin
    wait (!busy && !mute && clk_line === 1'b1 && dat_line === 1'b0);
    busy = 1'b1;
    #100;
    for (int i = 0; i < 10; i++) begin
      pulse();
      got[i] = dat_line;
    end
    // The acknowledge level stands on the line before the eleventh falling edge.
    dat_oe = !ack_bad;
    #100;
    pulse();
    dat_oe = 1'b0;
    busy = 1'b0;
    send((^got[8:0]) ? 8'hfa : 8'hfe, 1'b0);
  end
endmodule // pkl_periph

//--- verification/tb.sv
/* Self-checking bench for the host link controller.
   Assumes pulled-up lines and one peripheral model on each channel. */
`timescale 1ns/1ps
module tb import pkl_pkg::*;;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  pkl_pin_out_t ko, ao;
  pkl_pin_in_t  ki, ai;
  pkl_rx_t      kr, ar;
  logic [1:0]   kmode = 2'h2, mode;
  logic [7:0]   kdat = 8'h00, adat = 8'h00;
  logic         mload = 0, tren = 0, lock = 0, kval = 0, aval = 0, ktk = 0, atk = 0, kfree = 0;
  logic         krdy, kdone, knack, kres, ardy, adone, anack, ares, kto, ato, lkd, irq1, irq12;
  logic         kc, kd, ac, ad;
  logic [8:0]   kv, av;
  int           n_fail = 0, n_tests = 0;
  int           n_kv, n_av, n_done, n_nack, n_res, n_to, n_adone, n_i1, n_i12, n_aerr;

  // Pull-ups: a line is low while either party enables its drive.
  assign ki = {~(ko.clk_oe | kc), ~(ko.dat_oe | kd)};
  assign ai = {~(ao.clk_oe | ac), ~(ao.dat_oe | ad)};
  always #25 clk = ~clk;

  pkl_host #(.WATCHDOG_CYCLES(200)) dut (.clk(clk), .rst_b(rst_b), .kbd_in(ki), .kbd_out(ko),
    .aux_in(ai), .aux_out(ao), .kbd_mode(kmode), .mode_load(mload), .translate_en(tren),
    .lock_on(lock), .unlock_code(8'h5b), .kbd_tx_valid(kval), .kbd_tx_data(kdat),
    .kbd_tx_ready(krdy), .kbd_tx_done(kdone), .kbd_tx_nack(knack), .kbd_resend(kres),
    .aux_tx_valid(aval), .aux_tx_data(adat), .aux_tx_ready(ardy), .aux_tx_done(adone),
    .aux_tx_nack(anack), .aux_resend(ares), .kbd_rx(kr), .aux_rx(ar), .kbd_rx_taken(ktk),
    .aux_rx_taken(atk), .kbd_timeout(kto), .aux_timeout(ato), .locked(lkd), .mode(mode),
    .irq1(irq1), .irq12(irq12));
  pkl_periph u_kp (.clk_line(ki.clk_in), .dat_line(ki.dat_in), .clk_oe(kc), .dat_oe(kd));
  pkl_periph u_ap (.clk_line(ai.clk_in), .dat_line(ai.dat_in), .clk_oe(ac), .dat_oe(ad));

  // Tallies one-cycle outputs and frees the link after each delivered byte, finished command or timeout.
  always @(posedge clk) begin
    #1;
    if (kr.valid) kv = {kr.data, kr.parity_err};
    if (ar.valid) av = {ar.data, ar.parity_err};
    n_kv += kr.valid;
    n_av += ar.valid;
    n_done += kdone;
    n_nack += knack;
    n_res += kres;
    n_to += kto;
    n_adone += adone;
    n_i1 += irq1;
    n_i12 += irq12;
    n_aerr += anack | ares | ato;
    ktk = kr.valid | kdone | kto | kfree;
    atk = ar.valid | adone | ato;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic clr();
    {n_kv, n_av, n_done, n_nack, n_res, n_to, n_adone, n_i1, n_i12, n_aerr} = '0;
  endtask

  task automatic wait_n(ref int c);
    for (int i = 0; i < 4000 && c == 0; i++) @(posedge clk);
    #1;
  endtask

  // Holds a valid request until the edge at which ready is high.
  task automatic take(ref logic v, ref logic r);
    for (int i = 0; i < 4000 && !r; i++) @(posedge clk) #1;
    @(posedge clk);
    #1 v = 1'b0;
  endtask

  task automatic free_k();
    repeat (20) @(posedge clk);
    #1 kfree = 1'b1;
    @(posedge clk);
    #1 kfree = 1'b0;
  endtask

  task automatic load(input logic [1:0] m);
    kmode = m;
    mload = 1'b1;
    @(posedge clk);
    #1 mload = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_cmd(input logic [7:0] b, input logic bad);
    int c;
    clr();
    u_kp.ack_bad = bad;
    kdat = b;
    kval = 1'b1;
    take(kval, krdy);
    for (c = 0; !ko.dat_oe && c < 3000; c++) @(posedge clk) #1;
    // The clock is held from the taking edge through the edge that raises the request.
    check("inhibit", 12'(c), 12'(INHIBIT_CYC + 1));
    wait_n(n_done);
    check("nack", 12'(n_nack), 12'(bad));
    check("cmd", {2'h0, u_kp.got}, {2'h0, 1'b1, ~(^b), b});
    wait_n(n_kv);
    check("reply", {3'h0, kv}, {3'h0, CODE_ACK, 1'b0});
    check("irq1", 12'(n_i1), 12'd1);
    u_kp.ack_bad = 1'b0;
  endtask

  task automatic t_rx(input logic [7:0] b, input logic bp);
    clr();
    u_kp.send(b, bp);
    wait_n(n_kv);
    check("rx", {3'h0, kv}, {3'h0, b, bp});
    check("resend", 12'(n_res), 12'(b == CODE_RESEND));
  endtask

  task automatic t_clash();
    clr();
    u_kp.n_clash = 0;
    kdat = 8'h11;
    fork
      u_kp.send(8'h33, 1'b0);
      begin
        repeat (20) @(posedge clk);
        #1 kval = 1'b1;
      end
    join
    wait_n(n_kv);
    take(kval, krdy);
    check("clash", 12'(u_kp.n_clash), 12'd0);
    check("rx first", {3'h0, kv}, {3'h0, 8'h33, 1'b0});
    wait_n(n_done);
    check("cmd after", {4'h0, u_kp.got[7:0]}, 12'h011);
  endtask

  task automatic t_aux();
    clr();
    u_ap.send(8'h08, 1'b0);
    wait_n(n_av);
    check("aux rx", {3'h0, av}, {3'h0, 8'h08, 1'b0});
    check("irq12", 12'(n_i12), 12'd1);
    adat = 8'hf4;
    aval = 1'b1;
    take(aval, ardy);
    wait_n(n_adone);
    check("aux cmd", {4'h0, u_ap.got[7:0]}, 12'h0f4);
    check("aux errs", 12'(n_aerr), 12'd0);
  endtask

  task automatic t_mode();
    load(MODE_ONE);
    kval = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("mode one", {8'h0, mode, krdy, ko.clk_oe}, {8'h0, MODE_ONE, 2'b00});
    kval = 1'b0;
    load(MODE_THREE);
    check("mode three", {10'h0, mode}, {10'h0, MODE_THREE});
    check("ready", {11'h0, krdy}, 12'h001);
    load(MODE_TWO);
  endtask

  task automatic t_timeout();
    clr();
    u_kp.mute = 1'b1;
    kdat = 8'hee;
    kval = 1'b1;
    take(kval, krdy);
    wait_n(n_to);
    check("timeout", 12'(n_to), 12'd1);
    check("no done", {10'(n_done), ko.dat_oe, 1'b0}, 12'h0);
    repeat (10) @(posedge clk);
    u_kp.mute = 1'b0;
  endtask

  task automatic t_xlate();
    tren = 1'b1;
    clr();
    u_kp.send(CODE_BREAK, 1'b0);
    free_k();
    u_kp.send(8'h1c, 1'b0);
    wait_n(n_kv);
    check("xlate", {3'h0, kv}, {3'h0, 8'h1c | BREAK_BIT, 1'b0});
    tren = 1'b0;
    lock = 1'b1;
    @(posedge clk);
    #1 lock = 1'b0;
    clr();
    u_kp.send(8'h21, 1'b0);
    free_k();
    check("lock", {4'(n_kv), 7'h0, lkd}, 12'h001);
    u_kp.send(8'h5b, 1'b0);
    free_k();
    check("unlock", {11'h0, lkd}, 12'h000);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    check("reset", {5'h0, mode, ko, krdy}, {5'h0, MODE_TWO, 4'h0, 1'b1});
    t_cmd(8'hed, 1'b0);
    t_cmd(8'h5c, 1'b1);
    t_rx(8'h5a, 1'b1);
    t_rx(CODE_RESEND, 1'b0);
    t_clash();
    t_aux();
    t_mode();
    t_timeout();
    t_xlate();
    test_done();
  end

  // Cuts a hung run short.
  initial begin
    #3000000;
    n_fail++;
    test_done();
  end
endmodule // tb

//--- verilog/pkl_channel.sv
/*
  One host channel of the two-wire link: receive, inhibit, send, watchdog.
  Assumes the pins are open drain and resolved outside; link clock is raw.
*/
`timescale 1ns/1ps
module pkl_channel import pkl_pkg::*; #(
  parameter int unsigned INHIBIT_CYCLES  = INHIBIT_CYC,
  parameter int unsigned WATCHDOG_CYCLES = WATCHDOG_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire pkl_pin_in_t  pins_in,
  output pkl_pin_out_t      pins_out,
  input  wire logic         tx_allow,
  input  wire logic         tx_valid,
  input  wire logic [7:0]   tx_data,
  output logic              tx_ready,
  output logic              tx_done,
  output logic              tx_nack,
  output pkl_rx_t           rx,
  output logic              timeout,
  input  wire logic         hold_release,
  output logic              irq
);

  typedef struct packed {
    logic [1:0]  clk_sync;
    logic [1:0]  dat_sync;
    logic        clk_last;
    pkl_state_t  state;
    logic [3:0]  bit_idx;
    logic [10:0] shift;
    logic [7:0]  tx_byte;
    logic [20:0] timer;
    logic        drive_clk_low;
    logic        drive_dat_low;
    pkl_rx_t     rx;
    logic        tx_done;
    logic        tx_nack;
    logic        timeout;
    logic        irq;
  } pkl_chan_t;

  pkl_chan_t st_reg;
  pkl_chan_t st_next;
  logic      fall;

  // The link clock and data pass two flops before any logic looks at them.
  assign fall = st_reg.clk_last & ~st_reg.clk_sync[1];

  // Next state of the whole channel.
  always_comb begin
    st_next          = st_reg;
    st_next.clk_sync = {st_reg.clk_sync[0], pins_in.clk_in};
    st_next.dat_sync = {st_reg.dat_sync[0], pins_in.dat_in};
    st_next.clk_last = st_reg.clk_sync[1];
    st_next.rx.valid = 1'b0;
    st_next.tx_done  = 1'b0;
    st_next.tx_nack  = 1'b0;
    st_next.timeout  = 1'b0;
    st_next.irq      = 1'b0;
    if (st_reg.state != PKL_IDLE && st_reg.state != PKL_HOLD) begin
      st_next.timer = st_reg.timer + 21'h000001;
    end
    case (st_reg.state)
      PKL_IDLE: begin
        st_next.timer         = '0;
        st_next.bit_idx       = '0;
        st_next.drive_clk_low = 1'b0;
        st_next.drive_dat_low = 1'b0;
        if (fall && !st_reg.dat_sync[1]) begin
          st_next.state   = PKL_RX;
          st_next.bit_idx = 4'h1;
        end else if (tx_valid && tx_allow) begin
          st_next.state         = PKL_INHIBIT;
          st_next.tx_byte       = tx_data;
          st_next.drive_clk_low = 1'b1;
        end
      end
      PKL_RX: begin
        if (fall) begin
          st_next.timer   = '0;
          st_next.bit_idx = st_reg.bit_idx + 4'h1;
          st_next.shift   = {st_reg.dat_sync[1], st_reg.shift[10:1]};
          if (st_reg.bit_idx == BIT_STOP + 4'h1) begin
            st_next.state         = PKL_HOLD;
            st_next.drive_clk_low = 1'b1;
            st_next.rx.valid      = 1'b1;
            st_next.rx.data       = st_reg.shift[9:2];
            st_next.rx.parity_err = (^st_reg.shift[10:2]) != 1'b1;
            st_next.irq           = 1'b1;
          end
        end
        if (st_reg.timer >= 21'(WATCHDOG_CYCLES)) begin
          st_next.state   = PKL_IDLE;
          st_next.timeout = 1'b1;
        end
      end
      PKL_INHIBIT: begin
        if (st_reg.timer >= 21'(INHIBIT_CYCLES)) begin
          st_next.state         = PKL_REQ;
          st_next.timer         = '0;
          st_next.drive_dat_low = 1'b1;
          st_next.drive_clk_low = 1'b0;
          st_next.shift         = {2'b11, pkl_odd_parity(st_reg.tx_byte), st_reg.tx_byte};
          st_next.bit_idx       = '0;
        end
      end
      PKL_REQ: begin
        // The start bit is taken on the first falling edge.
        if (fall) begin
          st_next.state         = PKL_TX;
          st_next.timer         = '0;
          st_next.drive_dat_low = ~st_reg.shift[0];
          st_next.shift         = {1'b1, st_reg.shift[10:1]};
          st_next.bit_idx       = 4'h1;
        end
        if (st_reg.timer >= 21'(WATCHDOG_CYCLES)) begin
          st_next.state         = PKL_IDLE;
          st_next.drive_dat_low = 1'b0;
          st_next.timeout       = 1'b1;
        end
      end
      PKL_TX: begin
        if (fall) begin
          st_next.timer   = '0;
          st_next.bit_idx = st_reg.bit_idx + 4'h1;
          if (st_reg.bit_idx < BIT_STOP) begin
            st_next.drive_dat_low = ~st_reg.shift[0];
            st_next.shift         = {1'b1, st_reg.shift[10:1]};
          end else if (st_reg.bit_idx == BIT_STOP) begin
            st_next.drive_dat_low = 1'b0;
          end else begin
            st_next.state         = PKL_HOLD;
            st_next.drive_clk_low = 1'b1;
            st_next.tx_done       = 1'b1;
            st_next.tx_nack       = st_reg.dat_sync[1];
          end
        end
        if (st_reg.timer >= 21'(WATCHDOG_CYCLES)) begin
          st_next.state         = PKL_IDLE;
          st_next.drive_dat_low = 1'b0;
          st_next.timeout       = 1'b1;
        end
      end
      PKL_HOLD: begin
        if (hold_release) begin
          st_next.state         = PKL_IDLE;
          st_next.drive_clk_low = 1'b0;
        end
      end
      default: begin
        st_next.state = PKL_IDLE;
      end
    endcase
  end

  // Register the channel state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg          <= '0;
      st_reg.clk_sync <= 2'b11;
      st_reg.dat_sync <= 2'b11;
      st_reg.clk_last <= 1'b1;
      st_reg.state    <= PKL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Open-drain drive: the host only ever pulls low.
  assign pins_out.clk_out = 1'b0;
  assign pins_out.clk_oe  = st_reg.drive_clk_low;
  assign pins_out.dat_out = 1'b0;
  assign pins_out.dat_oe  = st_reg.drive_dat_low;
  // Ready drops in the cycle in which an inbound start bit wins the link.
  assign tx_ready         = (st_reg.state == PKL_IDLE) && tx_allow &&
                            !(fall && !st_reg.dat_sync[1]);
  assign tx_done          = st_reg.tx_done;
  assign tx_nack          = st_reg.tx_nack;
  assign rx               = st_reg.rx;
  assign timeout          = st_reg.timeout;
  assign irq              = st_reg.irq;

endmodule // pkl_channel

//--- verilog/pkl_host.sv
/*
  Host controller for a keyboard link and a pointing-device link.
  Assumes open-drain pins resolved outside, both link clocks made by the peripherals.
*/
`timescale 1ns/1ps
module pkl_host import pkl_pkg::*; #(
  parameter int unsigned WATCHDOG_CYCLES = WATCHDOG_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire pkl_pin_in_t  kbd_in,
  output pkl_pin_out_t      kbd_out,
  input  wire pkl_pin_in_t  aux_in,
  output pkl_pin_out_t      aux_out,
  input  wire logic [1:0]   kbd_mode,
  input  wire logic         mode_load,
  input  wire logic         translate_en,
  input  wire logic         lock_on,
  input  wire logic [7:0]   unlock_code,
  input  wire logic         kbd_tx_valid,
  input  wire logic [7:0]   kbd_tx_data,
  output logic              kbd_tx_ready,
  output logic              kbd_tx_done,
  output logic              kbd_tx_nack,
  output logic              kbd_resend,
  input  wire logic         aux_tx_valid,
  input  wire logic [7:0]   aux_tx_data,
  output logic              aux_tx_ready,
  output logic              aux_tx_done,
  output logic              aux_tx_nack,
  output logic              aux_resend,
  output pkl_rx_t           kbd_rx,
  output pkl_rx_t           aux_rx,
  input  wire logic         kbd_rx_taken,
  input  wire logic         aux_rx_taken,
  output logic              kbd_timeout,
  output logic              aux_timeout,
  output logic              locked,
  output logic [1:0]        mode,
  output logic              irq1,
  output logic              irq12
);

  typedef struct packed {
    logic [1:0] mode;
    logic       break_seen;
    logic       locked;
    pkl_rx_t    kbd_rx;
    pkl_rx_t    aux_rx;
    logic       kbd_resend;
    logic       aux_resend;
  } pkl_top_t;

  pkl_top_t     st_reg;
  pkl_top_t     st_next;
  pkl_rx_t      kbd_raw;
  pkl_rx_t      aux_raw;
  logic         kbd_irq_raw;
  logic         aux_irq_raw;

  // Keyboard channel; sending is only allowed outside mode one.
  pkl_channel #(
    .INHIBIT_CYCLES  (INHIBIT_CYC),
    .WATCHDOG_CYCLES (WATCHDOG_CYCLES)
  ) u_kbd (
    .clk          (clk),
    .rst_b        (rst_b),
    .pins_in      (kbd_in),
    .pins_out     (kbd_out),
    .tx_allow     (st_reg.mode != MODE_ONE),
    .tx_valid     (kbd_tx_valid),
    .tx_data      (kbd_tx_data),
    .tx_ready     (kbd_tx_ready),
    .tx_done      (kbd_tx_done),
    .tx_nack      (kbd_tx_nack),
    .rx           (kbd_raw),
    .timeout      (kbd_timeout),
    .hold_release (kbd_rx_taken),
    .irq          (kbd_irq_raw)
  );

  // Pointing-device channel with the same line control.
  pkl_channel #(
    .INHIBIT_CYCLES  (INHIBIT_CYC),
    .WATCHDOG_CYCLES (WATCHDOG_CYCLES)
  ) u_aux (
    .clk          (clk),
    .rst_b        (rst_b),
    .pins_in      (aux_in),
    .pins_out     (aux_out),
    .tx_allow     (1'b1),
    .tx_valid     (aux_tx_valid),
    .tx_data      (aux_tx_data),
    .tx_ready     (aux_tx_ready),
    .tx_done      (aux_tx_done),
    .tx_nack      (aux_tx_nack),
    .rx           (aux_raw),
    .timeout      (aux_timeout),
    .hold_release (aux_rx_taken),
    .irq          (aux_irq_raw)
  );

  // Mode, translation, lock and reply classification.
  always_comb begin
    st_next              = st_reg;
    st_next.kbd_rx.valid = 1'b0;
    st_next.aux_rx.valid = 1'b0;
    st_next.kbd_resend   = 1'b0;
    st_next.aux_resend   = 1'b0;
    if (mode_load) begin
      st_next.mode = kbd_mode;
    end
    if (kbd_raw.valid) begin
      st_next.kbd_resend = (kbd_raw.data == CODE_RESEND);
      if (st_reg.locked) begin
        if (kbd_raw.data == unlock_code) begin
          st_next.locked = 1'b0;
        end
      end else if (translate_en && kbd_raw.data == CODE_BREAK) begin
        st_next.break_seen = 1'b1;
      end else begin
        st_next.kbd_rx            = kbd_raw;
        st_next.break_seen        = 1'b0;
        if (translate_en && st_reg.break_seen) begin
          st_next.kbd_rx.data = kbd_raw.data | BREAK_BIT;
        end
      end
    end
    // Setting the lock wins over an unlock code that arrives in the same cycle.
    if (lock_on) begin
      st_next.locked = 1'b1;
    end
    if (aux_raw.valid) begin
      st_next.aux_resend = (aux_raw.data == CODE_RESEND);
      if (!st_reg.locked) begin
        st_next.aux_rx = aux_raw;
      end
    end
  end

  // Register the top-level state; mode two after reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg      <= '0;
      st_reg.mode <= MODE_TWO;
    end else begin
      st_reg <= st_next;
    end
  end

  assign kbd_rx     = st_reg.kbd_rx;
  assign aux_rx     = st_reg.aux_rx;
  assign kbd_resend = st_reg.kbd_resend;
  assign aux_resend = st_reg.aux_resend;
  assign locked     = st_reg.locked;
  assign mode       = st_reg.mode;
  // Interrupts pulse with a delivered byte on each channel.
  assign irq1       = st_reg.kbd_rx.valid;
  assign irq12      = st_reg.aux_rx.valid;

endmodule // pkl_host
